// ---- rtl/lcf_pkg.sv ----
// shared constants and types for the lcd command front end
package lcf_pkg;
   // slave address: upper six bits of the address byte, last bit r/w
   localparam logic [5:0] SLAVE_ADDR_HI = 6'h1c;
   localparam int ADDR_SEL_BIT = 1;
   localparam int RW_BIT = 0;
   // control byte fields
   localparam int CONT_BIT = 7;
   localparam int ROUTE_BIT = 6;
   // drive mode encodings
   localparam logic [1:0] MODE_STATIC = 2'h1;
   localparam logic [1:0] MODE_MUX2 = 2'h2;
   localparam logic [1:0] MODE_MUX3 = 2'h3;
   localparam logic [1:0] MODE_MUX4 = 2'h0;
   // pointer steps per stored byte
   localparam logic [6:0] STEP_STATIC = 7'h08;
   localparam logic [6:0] STEP_MUX2 = 7'h04;
   localparam logic [6:0] STEP_MUX3 = 7'h03;
   localparam logic [6:0] STEP_MUX4 = 7'h02;
   // opcode patterns
   localparam logic [3:0] OP_MODE = 4'hc;
   localparam logic [4:0] OP_DEVSEL = 5'h1c;
   localparam logic [5:0] OP_BANK = 6'h3e;
   localparam logic [4:0] OP_BLINK = 5'h1e;
   // apb register byte offsets
   localparam logic [7:0] REG_SETTINGS = 8'h00;
   localparam logic [7:0] REG_POINTER = 8'h04;
   localparam logic [7:0] REG_CONTROL = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   // reset values and byte width
   localparam logic RST_CONTROL_EN = 1'b1;
   localparam logic [6:0] RST_POINTER = 7'h00;
   localparam logic [2:0] RST_SUBADDR = 3'h0;
   localparam int BITS_PER_BYTE = 8;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_CTRL = 3'h3,
      ST_PAYLOAD = 3'h2,
      ST_IGNORE = 3'h6
   } lcf_state_type;

   typedef enum logic [2:0] {
      CMD_NONE, CMD_MODE, CMD_POINTER, CMD_DEVSEL, CMD_BANK, CMD_BLINK
   } lcf_cmd_type;

   typedef struct packed {
      logic display_enable;
      logic half_bias;
      logic [1:0] drive_mode;
      logic input_bank;
      logic output_bank;
      logic blink_alternate;
      logic [1:0] blink_rate_field;
   } lcf_settings_type;

   localparam lcf_settings_type RST_SETTINGS = '{
      display_enable: 1'b0, half_bias: 1'b0, drive_mode: MODE_MUX4,
      input_bank: 1'b0, output_bank: 1'b0, blink_alternate: 1'b0,
      blink_rate_field: 2'h0};

   typedef struct packed {
      logic strobe;
      logic [6:0] address;
      logic [7:0] data;
      logic bank;
   } lcf_ram_write_type;
endpackage

// ---- rtl/lcf_front_end.sv ----
// i2c write-only command front end with apb status and control
`timescale 1ns/1ps
module lcf_front_end #(
   parameter int PTR_WIDTH = 7
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // i2c pins
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   // strap pins
   input wire logic ADDRESS_SELECT_PIN,
   input wire logic CHIP_SUBADDRESS_PIN_0,
   input wire logic CHIP_SUBADDRESS_PIN_1,
   input wire logic CHIP_SUBADDRESS_PIN_2,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // display controller outputs
   output lcf_pkg::lcf_settings_type SETTINGS,
   output logic [6:0] RAM_POINTER,
   output logic [2:0] SUBADDRESS_COUNTER,
   output lcf_pkg::lcf_ram_write_type RAM_WRITE
);
   generate
      if (PTR_WIDTH != 7) begin : g_bad_width
         $error("lcf_front_end supports only a seven bit pointer");
      end
   endgenerate

   function automatic lcf_pkg::lcf_cmd_type decode_cmd(input logic [7:0] b);
      lcf_pkg::lcf_cmd_type c;
      c = lcf_pkg::CMD_NONE;
      if (!b[7])
         c = lcf_pkg::CMD_POINTER;
      else if (b[7:4] == lcf_pkg::OP_MODE)
         c = lcf_pkg::CMD_MODE;
      else if (b[7:3] == lcf_pkg::OP_DEVSEL)
         c = lcf_pkg::CMD_DEVSEL;
      else if (b[7:2] == lcf_pkg::OP_BANK)
         c = lcf_pkg::CMD_BANK;
      else if (b[7:3] == lcf_pkg::OP_BLINK)
         c = lcf_pkg::CMD_BLINK;
      return c;
   endfunction

   function automatic logic [6:0] ptr_step(input logic [1:0] mode);
      logic [6:0] s;
      s = lcf_pkg::STEP_MUX4;
      unique case (mode)
         lcf_pkg::MODE_STATIC: s = lcf_pkg::STEP_STATIC;
         lcf_pkg::MODE_MUX2: s = lcf_pkg::STEP_MUX2;
         lcf_pkg::MODE_MUX3: s = lcf_pkg::STEP_MUX3;
         lcf_pkg::MODE_MUX4: s = lcf_pkg::STEP_MUX4;
      endcase
      return s;
   endfunction

   // synchronisers: scl, sda, sa0, a2..a0
   logic [5:0] sync_a;
   logic [5:0] sync_b;
   logic scl_d;
   logic sda_d;
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         sync_a <= 6'h03;
         sync_b <= 6'h03;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         sync_a <= {CHIP_SUBADDRESS_PIN_2, CHIP_SUBADDRESS_PIN_1,
            CHIP_SUBADDRESS_PIN_0, ADDRESS_SELECT_PIN, SDA_IN, SCL};
         sync_b <= sync_a;
         scl_d <= sync_b[0];
         sda_d <= sync_b[1];
      end
   end

   logic scl_s, sda_s, sa0_s;
   logic [2:0] pins_s;
   assign scl_s = sync_b[0];
   assign sda_s = sync_b[1];
   assign sa0_s = sync_b[2];
   assign pins_s = sync_b[5:3];

   logic bus_enable, scl_rise, scl_fall, start_ev, stop_ev;
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   // sda change while scl stays high is a bus condition while bus_enable is set, never data
   assign start_ev = bus_enable && scl_s && scl_d && sda_d && !sda_s;
   assign stop_ev = bus_enable && scl_s && scl_d && !sda_d && sda_s;

   lcf_pkg::lcf_state_type state;
   logic [3:0] bit_cnt;
   logic [6:0] shreg;
   logic in_ack, ack_pending, cont_flag, byte_route_flag;

   logic receiving, byte_done, addr_match, sub_match, is_data;
   logic [7:0] byte_val;
   lcf_pkg::lcf_cmd_type cmd;
   assign receiving = (state == lcf_pkg::ST_ADDR) ||
      (state == lcf_pkg::ST_CTRL) || (state == lcf_pkg::ST_PAYLOAD);
   assign byte_done = receiving && scl_rise && !start_ev && !stop_ev &&
      (bit_cnt == 4'(lcf_pkg::BITS_PER_BYTE - 1));
   assign byte_val = {shreg, sda_s};
   assign addr_match = (byte_val[7:2] == lcf_pkg::SLAVE_ADDR_HI) &&
      (byte_val[lcf_pkg::ADDR_SEL_BIT] == sa0_s) &&
      !byte_val[lcf_pkg::RW_BIT];
   assign sub_match = (SUBADDRESS_COUNTER == pins_s);
   assign is_data = (state == lcf_pkg::ST_PAYLOAD) && byte_route_flag;
   assign cmd = decode_cmd(byte_val);

   // byte framing and acknowledge timing
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         bit_cnt <= 4'h0;
         shreg <= 7'h00;
         in_ack <= 1'b0;
         SDA_OE <= 1'b0;
      end else if (start_ev || stop_ev) begin
         bit_cnt <= 4'h0;
         in_ack <= 1'b0;
         SDA_OE <= 1'b0;
      end else if (!receiving) begin
         bit_cnt <= 4'h0;
         in_ack <= 1'b0;
         SDA_OE <= 1'b0;
      end else if (scl_rise && bit_cnt < 4'(lcf_pkg::BITS_PER_BYTE)) begin
         shreg <= byte_val[6:0];
         bit_cnt <= bit_cnt + 4'h1;
      end else if (scl_fall && bit_cnt == 4'(lcf_pkg::BITS_PER_BYTE)) begin
         // driven on the fall before the ninth pulse, released after it
         if (!in_ack) begin
            in_ack <= 1'b1;
            SDA_OE <= ack_pending;
         end else begin
            in_ack <= 1'b0;
            SDA_OE <= 1'b0;
            bit_cnt <= 4'h0;
         end
      end
   end
   // only the low level is ever driven
   assign SDA_OUT = 1'b0;

   // transfer sequencing
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         state <= lcf_pkg::ST_IDLE;
         ack_pending <= 1'b0;
         cont_flag <= 1'b0;
         byte_route_flag <= 1'b0;
      end else if (start_ev) begin
         state <= lcf_pkg::ST_ADDR;
         ack_pending <= 1'b0;
      end else if (stop_ev || !bus_enable) begin
         state <= lcf_pkg::ST_IDLE;
         ack_pending <= 1'b0;
      end else if (byte_done) begin
         unique case (state)
            lcf_pkg::ST_ADDR: begin
               state <= addr_match ? lcf_pkg::ST_CTRL :
                  lcf_pkg::ST_IGNORE;
               ack_pending <= addr_match;
            end
            lcf_pkg::ST_CTRL: begin
               cont_flag <= byte_val[lcf_pkg::CONT_BIT];
               byte_route_flag <= byte_val[lcf_pkg::ROUTE_BIT];
               ack_pending <= 1'b1;
               state <= lcf_pkg::ST_PAYLOAD;
            end
            default: begin
               ack_pending <= byte_route_flag ? sub_match : 1'b1;
               state <= cont_flag ? lcf_pkg::ST_CTRL :
                  lcf_pkg::ST_PAYLOAD;
            end
         endcase
      end
   end

   // display controller: command execution and settings
   logic two_bank;
   assign two_bank = (SETTINGS.drive_mode == lcf_pkg::MODE_STATIC) ||
      (SETTINGS.drive_mode == lcf_pkg::MODE_MUX2);
   logic blink_alt_raw;
   logic cmd_go;
   assign cmd_go = byte_done && (state == lcf_pkg::ST_PAYLOAD) &&
      !byte_route_flag;

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         SETTINGS.display_enable <= lcf_pkg::RST_SETTINGS.display_enable;
         SETTINGS.half_bias <= lcf_pkg::RST_SETTINGS.half_bias;
         SETTINGS.drive_mode <= lcf_pkg::RST_SETTINGS.drive_mode;
         SETTINGS.input_bank <= lcf_pkg::RST_SETTINGS.input_bank;
         SETTINGS.output_bank <= lcf_pkg::RST_SETTINGS.output_bank;
         SETTINGS.blink_rate_field <= lcf_pkg::RST_SETTINGS.blink_rate_field;
         blink_alt_raw <= lcf_pkg::RST_SETTINGS.blink_alternate;
         SETTINGS.blink_alternate <= lcf_pkg::RST_SETTINGS.blink_alternate;
      end else begin
         // alternation is kept but masked while the mode lacks a second bank
         SETTINGS.blink_alternate <= blink_alt_raw && two_bank;
         if (cmd_go) begin
            unique case (cmd)
               lcf_pkg::CMD_MODE: begin
                  SETTINGS.display_enable <= byte_val[3];
                  SETTINGS.half_bias <= byte_val[2];
                  SETTINGS.drive_mode <= byte_val[1:0];
               end
               lcf_pkg::CMD_BANK: begin
                  // no alternate bank exists in three/four-way drive
                  if (two_bank) begin
                     SETTINGS.input_bank <= byte_val[1];
                     SETTINGS.output_bank <= byte_val[0];
                  end
               end
               lcf_pkg::CMD_BLINK: begin
                  blink_alt_raw <= byte_val[2];
                  SETTINGS.blink_rate_field <= byte_val[1:0];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // pointer, subaddress counter and ram write port
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         RAM_POINTER <= lcf_pkg::RST_POINTER;
         SUBADDRESS_COUNTER <= lcf_pkg::RST_SUBADDR;
      end else if (cmd_go && cmd == lcf_pkg::CMD_POINTER) begin
         RAM_POINTER <= byte_val[6:0];
      end else if (cmd_go && cmd == lcf_pkg::CMD_DEVSEL) begin
         SUBADDRESS_COUNTER <= byte_val[2:0];
      end else if (byte_done && is_data) begin
         // advance even on mismatch so cascaded parts stay aligned
         RAM_POINTER <= RAM_POINTER + ptr_step(SETTINGS.drive_mode);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         RAM_WRITE <= '0;
      end else begin
         RAM_WRITE.strobe <= byte_done && is_data && sub_match;
         if (byte_done && is_data) begin
            RAM_WRITE.address <= RAM_POINTER;
            RAM_WRITE.data <= byte_val;
            RAM_WRITE.bank <= SETTINGS.input_bank;
         end
      end
   end

   // apb slave, zero wait states; read data latched in setup phase
   logic apb_setup;
   logic apb_wr;
   logic addr_ok;
   assign apb_setup = PSEL && !PENABLE;
   assign apb_wr = PSEL && PENABLE && PWRITE;
   assign addr_ok = (PADDR == lcf_pkg::REG_SETTINGS) ||
      (PADDR == lcf_pkg::REG_POINTER) || (PADDR == lcf_pkg::REG_CONTROL) ||
      (PADDR == lcf_pkg::REG_STATUS);
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !addr_ok;

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N)
         bus_enable <= lcf_pkg::RST_CONTROL_EN;
      else if (apb_wr && PADDR == lcf_pkg::REG_CONTROL)
         bus_enable <= PWDATA[0];
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         PRDATA <= 32'h0;
      end else if (apb_setup) begin
         unique case (PADDR)
            lcf_pkg::REG_SETTINGS: PRDATA <= {23'h0, SETTINGS};
            lcf_pkg::REG_POINTER:
               PRDATA <= {21'h0, SUBADDRESS_COUNTER, 1'b0, RAM_POINTER};
            lcf_pkg::REG_CONTROL: PRDATA <= {31'h0, bus_enable};
            lcf_pkg::REG_STATUS:
               PRDATA <= {24'h0, pins_s, sa0_s, 1'b0, state};
            default: PRDATA <= 32'h0;
         endcase
      end
   end

   // checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);

   sequence s_addr_byte_read;
      byte_done && state == lcf_pkg::ST_ADDR && byte_val[lcf_pkg::RW_BIT];
   endsequence
   sequence s_ack_window;
      scl_fall && bit_cnt == 4'h8 && !in_ack && ack_pending && receiving &&
         !start_ev && !stop_ev;
   endsequence

   property p_start;
      start_ev |=> state == lcf_pkg::ST_ADDR && !SDA_OE;
   endproperty
   a_start: assert property (p_start)
      else $error("start not detected");
   property p_stop;
      stop_ev && !start_ev |=> state == lcf_pkg::ST_IDLE;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop not detected");
   property p_read_ignored;
      s_addr_byte_read |=> state == lcf_pkg::ST_IGNORE;
   endproperty
   a_read_ignored: assert property (p_read_ignored)
      else $error("read address accepted");
   property p_ignore_quiet;
      state == lcf_pkg::ST_IGNORE |=> !SDA_OE;
   endproperty
   a_ignore_quiet: assert property (p_ignore_quiet)
      else $error("ignored transfer drove sda");
   property p_ack_held;
      s_ack_window ##1 (!scl_fall && receiving && !start_ev && !stop_ev)[*4]
         |-> SDA_OE;
   endproperty
   a_ack_held: assert property (p_ack_held)
      else $error("acknowledge released early");
   property p_write_match;
      RAM_WRITE.strobe |-> $past(sub_match);
   endproperty
   a_write_match: assert property (p_write_match)
      else $error("ram write without subaddress match");
   property p_ptr_step;
      byte_done && is_data && !start_ev |=>
         RAM_POINTER == $past(RAM_POINTER) + ptr_step(SETTINGS.drive_mode);
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("pointer step wrong");
   property p_ptr_load;
      cmd_go && cmd == lcf_pkg::CMD_POINTER |=>
         RAM_POINTER == $past(byte_val[6:0]);
   endproperty
   a_ptr_load: assert property (p_ptr_load)
      else $error("pointer load failed");
   property p_bank_blocked;
      cmd_go && cmd == lcf_pkg::CMD_BANK && !two_bank |=>
         $stable(SETTINGS.input_bank) && $stable(SETTINGS.output_bank);
   endproperty
   a_bank_blocked: assert property (p_bank_blocked)
      else $error("bank changed in three/four-way mode");
   property p_cont_single;
      byte_done && state == lcf_pkg::ST_PAYLOAD && cont_flag && bus_enable
         |=> state == lcf_pkg::ST_CTRL;
   endproperty
   a_cont_single: assert property (p_cont_single)
      else $error("control byte not expected after single byte");
endmodule

// ---- testbench/lcf_i2c_master.sv ----
// behavioural i2c bus master driving scl and an open-drain sda
`timescale 1ns/1ps
module lcf_i2c_master (
   // clock
   input wire logic SYS_CLK,
   // resolved sda wire
   input wire logic SDA,
   // bus drives, 1 means released
   output logic SCL,
   output logic SDA_DRIVE
);
   int collisions = 0;
   initial begin
      SCL = 1'b1;
      SDA_DRIVE = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge SYS_CLK);
   endtask
   // usable from idle and as a repeated start
   task automatic start();
      SDA_DRIVE <= 1'b1;
      tick(2);
      SCL <= 1'b1;
      tick(2);
      SDA_DRIVE <= 1'b0;
      tick(2);
      SCL <= 1'b0;
      tick(2);
   endtask
   task automatic stop();
      SDA_DRIVE <= 1'b0;
      tick(2);
      SCL <= 1'b1;
      tick(2);
      SDA_DRIVE <= 1'b1;
      tick(4);
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic [2:0] s;
      for (int i = 7; i >= 0; i--) begin
         tick(2);
         SDA_DRIVE <= b[i];
         tick(2);
         SCL <= 1'b1;
         tick(2);
         // the device may only pull sda during acknowledge
         if (SDA !== b[i]) collisions++;
         tick(2);
         SCL <= 1'b0;
      end
      tick(2);
      SDA_DRIVE <= 1'b1;
      // long low phase leaves room for the device's sync delay
      tick(6);
      SCL <= 1'b1;
      tick(1);
      s[0] = SDA;
      tick(2);
      s[1] = SDA;
      tick(1);
      s[2] = SDA;
      SCL <= 1'b0;
      tick(6);
      ack = (s === 3'b000);
   endtask
endmodule

// ---- testbench/test_lcf_front_end.sv ----
// self-checking bench for the lcd command front end
`timescale 1ns/1ps
`define CHECK(got, exp) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("MISMATCH %0t got %h exp %h", $time, got, exp); \
   end \
end
module test_lcf_front_end;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic scl, sda_drive, sda_oe, sda_out, sda;
   logic sa0 = 1'b0;
   logic [2:0] pins = 3'h0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, ack, e;
   lcf_pkg::lcf_settings_type settings, exp_s;
   lcf_pkg::lcf_ram_write_type ram_write, last_wr;
   logic [6:0] ptr;
   logic [2:0] sub;
   int bad_count = 0;
   int comparisons = 0;
   int wr_count = 0;
   int n;
   logic [1:0] modes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
   logic [6:0] steps [4] = '{7'h08, 7'h04, 7'h03, 7'h02};
   assign sda = sda_drive & ~sda_oe;
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (ram_write.strobe === 1'b1) begin
         wr_count++;
         last_wr = ram_write;
      end
   end
   lcf_i2c_master u_lcf_i2c_master (.SYS_CLK(sys_clk), .SDA(sda),
      .SCL(scl), .SDA_DRIVE(sda_drive));
   lcf_front_end u_lcf_front_end (.SYS_CLK(sys_clk), .RESET_N(reset_n),
      .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
      .ADDRESS_SELECT_PIN(sa0), .CHIP_SUBADDRESS_PIN_0(pins[0]),
      .CHIP_SUBADDRESS_PIN_1(pins[1]), .CHIP_SUBADDRESS_PIN_2(pins[2]),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SETTINGS(settings), .RAM_POINTER(ptr),
      .SUBADDRESS_COUNTER(sub), .RAM_WRITE(ram_write));
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle cycle so a following setup never lands in this step
      @(posedge sys_clk);
   endtask
   task automatic tx(input logic [7:0] b, input logic x);
      u_lcf_i2c_master.send_byte(b, ack);
      `CHECK(ack, x)
   endtask
   initial begin
      exp_s = lcf_pkg::RST_SETTINGS;
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      `CHECK(settings, lcf_pkg::RST_SETTINGS)
      `CHECK(ptr, 7'h00)
      `CHECK(sda_oe, 1'b0)
      `CHECK(sda_out, 1'b0)
      apb(1'b1, 8'h00, 32'h1ff);
      apb(1'b0, 8'h00, 32'h0);
      `CHECK(rd, 32'h0)
      apb(1'b0, 8'h10, 32'h0);
      `CHECK(err, 1'b1)
      `CHECK(rd, 32'h0)
      apb(1'b0, 8'h08, 32'h0);
      `CHECK(rd, 32'h1)
      apb(1'b1, 8'h08, 32'h0);
      u_lcf_i2c_master.start();
      tx(8'h70, 1'b0);
      u_lcf_i2c_master.stop();
      apb(1'b1, 8'h08, 32'h1);
      for (int s = 0; s < 2; s++) begin
         sa0 <= s[0];
         repeat (4) @(posedge sys_clk);
         for (int i = 8'h6e; i < 8'h76; i++) begin
            e = (i[7:0] == {lcf_pkg::SLAVE_ADDR_HI, s[0], 1'b0});
            u_lcf_i2c_master.start();
            tx(i[7:0], e);
            tx(8'h00, e);
            tx(e ? 8'hc0 : 8'hcf, e);
            u_lcf_i2c_master.stop();
            `CHECK(settings, lcf_pkg::RST_SETTINGS)
         end
      end
      sa0 <= 1'b0;
      pins <= 3'h5;
      u_lcf_i2c_master.start();
      tx(8'h70, 1'b1);
      tx(8'h00, 1'b1);
      for (int m = 0; m < 4; m++) begin
         tx({4'hc, m[0], m[1], m[1:0]}, 1'b1);
         exp_s.display_enable = m[0];
         exp_s.half_bias = m[1];
         exp_s.drive_mode = m[1:0];
         `CHECK(settings, exp_s)
      end
      tx(8'hfb, 1'b1);
      tx(8'hf7, 1'b1);
      tx(8'hd3, 1'b1);
      tx(8'hff, 1'b1);
      exp_s.blink_rate_field = 2'h3;
      `CHECK(settings, exp_s)
      tx(8'hc9, 1'b1);
      exp_s.display_enable = 1'b1;
      exp_s.half_bias = 1'b0;
      exp_s.drive_mode = 2'h1;
      exp_s.blink_alternate = 1'b1;
      `CHECK(settings, exp_s)
      tx(8'hfb, 1'b1);
      exp_s.input_bank = 1'b1;
      exp_s.output_bank = 1'b1;
      `CHECK(settings, exp_s)
      tx(8'hf0, 1'b1);
      exp_s.blink_alternate = 1'b0;
      exp_s.blink_rate_field = 2'h0;
      `CHECK(settings, exp_s)
      tx(8'he5, 1'b1);
      `CHECK(sub, 3'h5)
      tx(8'h3b, 1'b1);
      `CHECK(ptr, 7'h3b)
      for (int m = 0; m < 4; m++) begin
         u_lcf_i2c_master.start();
         tx(8'h70, 1'b1);
         tx(8'hbf, 1'b1);
         tx({4'hc, 2'b11, modes[m]}, 1'b1);
         `CHECK(settings.drive_mode, modes[m])
         tx(8'h80, 1'b1);
         tx(8'he5, 1'b1);
         tx(8'h9a, 1'b1);
         tx(8'h0a, 1'b1);
         tx(8'hea, 1'b1);
         n = wr_count;
         tx(8'ha5, 1'b1);
         `CHECK(wr_count, n + 1)
         `CHECK(last_wr.address, 7'h0a)
         `CHECK(last_wr.data, 8'ha5)
         if (m < 2) `CHECK(last_wr.bank, 1'b1)
         `CHECK(ptr, 7'(7'h0a + steps[m]))
         tx(8'h95, 1'b1);
         tx(8'he2, 1'b1);
         tx(8'h6b, 1'b1);
         tx(8'h3c, 1'b0);
         `CHECK(wr_count, n + 1)
         `CHECK(ptr, 7'(7'h0a + 2 * steps[m]))
      end
      u_lcf_i2c_master.stop();
      apb(1'b0, 8'h04, 32'h0);
      `CHECK(rd, 32'h20e)
      apb(1'b0, 8'h0c, 32'h0);
      `CHECK(rd, 32'ha0)
      exp_s.half_bias = 1'b1;
      exp_s.drive_mode = 2'h0;
      apb(1'b0, 8'h00, 32'h0);
      `CHECK(rd, 32'(exp_s))
      `CHECK(u_lcf_i2c_master.collisions, 0)
      conclude();
   end
endmodule
